//--- core/rtes_defines.vh
// constants for the rail two enable sequencing block
`ifndef RTES_DEFINES_VH
`define RTES_DEFINES_VH

// register offsets
`define RTES_ADDR_W             8
`define RTES_OFS_MASK_A         8'h0a
`define RTES_OFS_ENABLE_SEL     8'h0b
`define RTES_OFS_EDGE_DELAY     8'h0c

// reset values before the one-time defaults are taken
`define RTES_RST_MASK_A         8'h00
`define RTES_RST_ENABLE_SEL     8'hc0
`define RTES_RST_EDGE_DELAY     8'h00
`define RTES_RDATA_UNMAPPED     8'h00

// first control register fields
`define RTES_BIT_AUX_THREE      7
`define RTES_BIT_AUX_TWO        6
`define RTES_BIT_SW_A_ONE       5
`define RTES_BIT_CONV_SIX       4
`define RTES_BIT_CONV_FIVE      3
`define RTES_BIT_CONV_FOUR      2
`define RTES_BIT_CONV_THREE     1
`define RTES_BIT_CONV_ONE       0

// second control register fields
`define RTES_BIT_STEP_SIZE      5
`define RTES_SRC_HI             4
`define RTES_SRC_LO             2
`define RTES_BIT_SW_B_TWO       1
`define RTES_BIT_SW_B_ONE       0

// third control register fields
`define RTES_FALL_HI            5
`define RTES_FALL_LO            3
`define RTES_RISE_HI            2
`define RTES_RISE_LO            0

// enable source codes
`define RTES_SRC_PIN_FIRST      3'h0
`define RTES_SRC_PIN_SECOND     3'h1
`define RTES_SRC_PIN_FIFTH      3'h2
`define RTES_SRC_PIN_FOURTH     3'h3
`define RTES_SRC_PIN_THIRD      3'h4
`define RTES_SRC_THIRD_FOURTH   3'h5
`define RTES_SRC_PIN_SIXTH      3'h6
`define RTES_SRC_CONST_ONE      3'h7

// control pin indices in the pin vector
`define RTES_PIN_FIRST          0
`define RTES_PIN_SECOND         1
`define RTES_PIN_THIRD          2
`define RTES_PIN_FOURTH         3
`define RTES_PIN_FIFTH          4
`define RTES_PIN_SIXTH          5
`define RTES_NUM_PINS           6
`define RTES_NUM_GOOD           10

// delay codes and their lengths in ms
`define RTES_DLY_CODE_0         3'h0
`define RTES_DLY_CODE_1         3'h1
`define RTES_DLY_CODE_2         3'h2
`define RTES_DLY_CODE_3         3'h3
`define RTES_DLY_CODE_4         3'h4
`define RTES_DLY_CODE_5         3'h5
`define RTES_DLY_CODE_6         3'h6
`define RTES_DLY_MS_0           7'h00
`define RTES_DLY_MS_1           7'h02
`define RTES_DLY_MS_2           7'h04
`define RTES_DLY_MS_3           7'h08
`define RTES_DLY_MS_4           7'h10
`define RTES_DLY_MS_5           7'h18
`define RTES_DLY_MS_6           7'h20
`define RTES_DLY_MS_7           7'h40
`define RTES_MS_W               7

// timing: clock rate and one millisecond in cycles
`define RTES_CLK_HZ             250000000
`define RTES_MS_PER_S           1000
`define RTES_MS_CYCLES          (`RTES_CLK_HZ / `RTES_MS_PER_S)
`define RTES_PRESC_W            20

`endif

//--- core/rtes_sync.v
// two flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module rtes_sync #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // pins in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg stable_q;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end
        else
        begin
          meta_q   <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule // rtes_sync

`default_nettype wire

//--- core/rtes_top.v
// enable sequencing for converter two: source select, good masking, edge delays
//
// Overview of operation
// [RULE1] first register bit 7 set masks aux regulator three good from enabling.
// [RULE2] first register bit 6 set masks aux regulator two good from enabling.
// [RULE3] first register bit 5 set masks load switch a one good.
// [RULE4] first register bit 4 set masks converter six good.
// [RULE5] first register bit 3 set masks converter five good.
// [RULE6] first register bit 2 set masks converter four good.
// [RULE7] first register bit 1 set masks converter three good.
// [RULE8] first register bit 0 set masks converter one good.
// [RULE9] second register bit 1 set masks switch b two with aux one good.
// [RULE10] second register bit 0 set masks load switch b one good.
// [RULE11] second register bit 5 picks step size: 0 is 10 mV, 1 is 25 mV.
// [RULE12] second register bits 4:2 pick which control pin enables the rail.
// [RULE13] source code 101 needs both third and fourth control pins high.
// [RULE14] source code 111 feeds constant one; no pin needed.
// [RULE15] third register bits 5:3 pick falling edge delay, none up to 64 ms.
// [RULE16] third register bits 2:0 pick rising edge delay, none up to 64 ms.
// [RULE17] host changes step size only through the factory programming flow; the code lets a register write to 8'h0b change bit 5.
// [RULE18] rail enables when source true and all unmasked goods true, after delay.
// [RULE19] reset values come from one-time defaults; bits 7:6 kept as storage.
// [RULE20] delay counted in ms ticks; the pending edge is dropped if the gated enable level goes back early.
`timescale 1ns/1ps
`default_nettype none
`include "rtes_defines.vh"

module rtes_top #(
  parameter MS_CYCLES = `RTES_MS_CYCLES
) (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst_n,
  // register access port
  input  wire [`RTES_ADDR_W-1:0]  reg_addr,
  input  wire                     reg_wr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_rd,
  output reg  [7:0]               reg_rdata_q,
  // one-time programmed defaults
  input  wire [7:0]               otp_mask_a,
  input  wire [7:0]               otp_enable_select,
  input  wire [7:0]               otp_edge_delay,
  // control pins, index 0 is control_pin_first
  input  wire [`RTES_NUM_PINS-1:0] control_pin,
  // power good of the other rails
  input  wire                     power_good_converter_one,
  input  wire                     power_good_converter_three,
  input  wire                     power_good_converter_four,
  input  wire                     power_good_converter_five,
  input  wire                     power_good_converter_six,
  input  wire                     power_good_load_switch_a_one,
  input  wire                     power_good_aux_regulator_two,
  input  wire                     power_good_aux_regulator_three,
  input  wire                     power_good_load_switch_b_one,
  input  wire                     power_good_switch_b_two_aux_reg_one,
  // rail control
  output reg                      converter_two_enable_q,
  output reg                      rail_two_step_size_q,
  output reg                      delay_pending_q
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [`RTES_PRESC_W-1:0] PRESC_LAST = MS_CYCLES[`RTES_PRESC_W-1:0] - 1'b1;

  // configuration registers
  reg  [7:0] mask_a_q;
  reg  [7:0] enable_sel_q;
  reg  [7:0] edge_delay_q;
  reg        otp_load_q;

  // sequencing state
  reg  [1:0]               state_q;
  reg  [1:0]               state_d;
  reg                      target_q;
  reg                      target_d;
  reg                      enable_d;
  reg                      pending_d;
  reg  [`RTES_PRESC_W-1:0] presc_q;
  reg  [`RTES_PRESC_W-1:0] presc_d;
  reg  [`RTES_MS_W-1:0]    ms_cnt_q;
  reg  [`RTES_MS_W-1:0]    ms_cnt_d;

  // synchronised pins
  wire [`RTES_NUM_PINS-1:0] pin_s;
  wire [`RTES_NUM_GOOD-1:0] good_s;
  wire [`RTES_NUM_GOOD-1:0] good_raw;
  wire [`RTES_NUM_GOOD-1:0] good_mask;
  wire [`RTES_NUM_GOOD-1:0] good_ok;

  assign good_raw = {power_good_switch_b_two_aux_reg_one, power_good_load_switch_b_one,
                     power_good_aux_regulator_three, power_good_aux_regulator_two,
                     power_good_load_switch_a_one, power_good_converter_six,
                     power_good_converter_five, power_good_converter_four,
                     power_good_converter_three, power_good_converter_one};

  rtes_sync #(
    .WIDTH (`RTES_NUM_PINS + `RTES_NUM_GOOD)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({good_raw, control_pin}),
    .sync_out ({good_s, pin_s})
  );

  // mask bits laid out in the same order as good_raw
  assign good_mask[0] = mask_a_q[`RTES_BIT_CONV_ONE];         // [RULE8]
  assign good_mask[1] = mask_a_q[`RTES_BIT_CONV_THREE];       // [RULE7]
  assign good_mask[2] = mask_a_q[`RTES_BIT_CONV_FOUR];        // [RULE6]
  assign good_mask[3] = mask_a_q[`RTES_BIT_CONV_FIVE];        // [RULE5]
  assign good_mask[4] = mask_a_q[`RTES_BIT_CONV_SIX];         // [RULE4]
  assign good_mask[5] = mask_a_q[`RTES_BIT_SW_A_ONE];         // [RULE3]
  assign good_mask[6] = mask_a_q[`RTES_BIT_AUX_TWO];          // [RULE2]
  assign good_mask[7] = mask_a_q[`RTES_BIT_AUX_THREE];        // [RULE1]
  assign good_mask[8] = enable_sel_q[`RTES_BIT_SW_B_ONE];     // [RULE10]
  assign good_mask[9] = enable_sel_q[`RTES_BIT_SW_B_TWO];     // [RULE9]

  // a masked good counts as true
  genvar g;
  generate
    for (g = 0; g < `RTES_NUM_GOOD; g = g + 1)
    begin : g_good
      assign good_ok[g] = good_mask[g] | good_s[g];
    end
  endgenerate

  // enable source multiplexer
  reg source_sel;
  always @*
  begin
    case (enable_sel_q[`RTES_SRC_HI:`RTES_SRC_LO])      // [RULE12]
      `RTES_SRC_PIN_FIRST:    source_sel = pin_s[`RTES_PIN_FIRST];
      `RTES_SRC_PIN_SECOND:   source_sel = pin_s[`RTES_PIN_SECOND];
      `RTES_SRC_PIN_FIFTH:    source_sel = pin_s[`RTES_PIN_FIFTH];
      `RTES_SRC_PIN_FOURTH:   source_sel = pin_s[`RTES_PIN_FOURTH];
      `RTES_SRC_PIN_THIRD:    source_sel = pin_s[`RTES_PIN_THIRD];
      `RTES_SRC_THIRD_FOURTH: source_sel = pin_s[`RTES_PIN_THIRD] & pin_s[`RTES_PIN_FOURTH]; // [RULE13]
      `RTES_SRC_PIN_SIXTH:    source_sel = pin_s[`RTES_PIN_SIXTH];
      `RTES_SRC_CONST_ONE:    source_sel = 1'b1;                                             // [RULE14]
      default:                source_sel = 1'b0;
    endcase
  end

  // gated enable request
  wire gated_en = source_sel & (&good_ok);                  // [RULE18]

  // delay code to milliseconds
  function [`RTES_MS_W-1:0] dly_ms;
    input [2:0] code;
    begin
      case (code)
        `RTES_DLY_CODE_0: dly_ms = `RTES_DLY_MS_0;
        `RTES_DLY_CODE_1: dly_ms = `RTES_DLY_MS_1;
        `RTES_DLY_CODE_2: dly_ms = `RTES_DLY_MS_2;
        `RTES_DLY_CODE_3: dly_ms = `RTES_DLY_MS_3;
        `RTES_DLY_CODE_4: dly_ms = `RTES_DLY_MS_4;
        `RTES_DLY_CODE_5: dly_ms = `RTES_DLY_MS_5;
        `RTES_DLY_CODE_6: dly_ms = `RTES_DLY_MS_6;
        default:          dly_ms = `RTES_DLY_MS_7;
      endcase
    end
  endfunction

  wire [`RTES_MS_W-1:0] rise_ms = dly_ms(edge_delay_q[`RTES_RISE_HI:`RTES_RISE_LO]);  // [RULE16]
  wire [`RTES_MS_W-1:0] fall_ms = dly_ms(edge_delay_q[`RTES_FALL_HI:`RTES_FALL_LO]);  // [RULE15]
  wire [`RTES_MS_W-1:0] new_ms  = gated_en ? rise_ms : fall_ms;
  wire [`RTES_MS_W-1:0] tgt_ms  = target_q ? rise_ms : fall_ms;
  wire                  ms_tick = (presc_q == PRESC_LAST);

  // sequencing state machine
  always @*
  begin
    state_d   = state_q;
    target_d  = target_q;
    enable_d  = converter_two_enable_q;
    presc_d   = presc_q;
    ms_cnt_d  = ms_cnt_q;
    pending_d = delay_pending_q;
    case (state_q)
      ST_IDLE:
      begin
        presc_d  = {`RTES_PRESC_W{1'b0}};
        ms_cnt_d = {`RTES_MS_W{1'b0}};
        if (gated_en != converter_two_enable_q)
        begin
          if (new_ms == `RTES_DLY_MS_0)
            enable_d = gated_en;                             // [RULE18]
          else
          begin
            state_d   = ST_WAIT;
            target_d  = gated_en;
            pending_d = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (gated_en != target_q)
        begin
          // level went back before expiry: drop this edge
          state_d   = ST_IDLE;                               // [RULE20]
          pending_d = 1'b0;
          presc_d   = {`RTES_PRESC_W{1'b0}};
          ms_cnt_d  = {`RTES_MS_W{1'b0}};
        end
        else if (ms_tick)
        begin
          presc_d  = {`RTES_PRESC_W{1'b0}};
          ms_cnt_d = ms_cnt_q + 1'b1;                        // [RULE20]
          if (ms_cnt_q + 1'b1 >= tgt_ms)
          begin
            enable_d  = target_q;                            // [RULE18]
            state_d   = ST_IDLE;
            pending_d = 1'b0;
            ms_cnt_d  = {`RTES_MS_W{1'b0}};
          end
        end
        else
          presc_d = presc_q + 1'b1;
      end
      default:
      begin
        state_d   = ST_IDLE;
        pending_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q                <= ST_IDLE;
      target_q               <= 1'b0;
      converter_two_enable_q <= 1'b0;
      delay_pending_q        <= 1'b0;
      presc_q                <= {`RTES_PRESC_W{1'b0}};
      ms_cnt_q               <= {`RTES_MS_W{1'b0}};
    end
    else
    begin
      state_q                <= state_d;
      target_q               <= target_d;
      converter_two_enable_q <= enable_d;
      delay_pending_q        <= pending_d;
      presc_q                <= presc_d;
      ms_cnt_q               <= ms_cnt_d;
    end
  end

  // configuration registers, loaded from defaults on the first edge after reset
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_a_q     <= `RTES_RST_MASK_A;
      enable_sel_q <= `RTES_RST_ENABLE_SEL;
      edge_delay_q <= `RTES_RST_EDGE_DELAY;
      otp_load_q   <= 1'b1;
    end
    else if (otp_load_q)
    begin
      mask_a_q     <= otp_mask_a;                            // [RULE19]
      enable_sel_q <= otp_enable_select;                     // [RULE19]
      edge_delay_q <= otp_edge_delay;                        // [RULE19]
      otp_load_q   <= 1'b0;
    end
    else if (reg_wr)
    begin
      // full byte stored, reserved bits 7:6 included
      case (reg_addr)
        `RTES_OFS_MASK_A:     mask_a_q     <= reg_wdata;
        `RTES_OFS_ENABLE_SEL: enable_sel_q <= reg_wdata;     // [RULE19]
        `RTES_OFS_EDGE_DELAY: edge_delay_q <= reg_wdata;     // [RULE19]
        default:              mask_a_q     <= mask_a_q;
      endcase
    end
  end

  // read data and step size
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q          <= `RTES_RDATA_UNMAPPED;
      rail_two_step_size_q <= 1'b0;
    end
    else
    begin
      rail_two_step_size_q <= enable_sel_q[`RTES_BIT_STEP_SIZE];  // [RULE11]
      if (reg_rd)
      begin
        case (reg_addr)
          `RTES_OFS_MASK_A:     reg_rdata_q <= mask_a_q;
          `RTES_OFS_ENABLE_SEL: reg_rdata_q <= enable_sel_q;
          `RTES_OFS_EDGE_DELAY: reg_rdata_q <= edge_delay_q;
          default:              reg_rdata_q <= `RTES_RDATA_UNMAPPED;
        endcase
      end
    end
  end

endmodule // rtes_top

`default_nettype wire

//--- testbench/rtes_pins_model.sv
// far-side model: control pins and power-good levels of the other rails
`timescale 1ns/1ps
`default_nettype none

module rtes_pins_model (
  // clock
  input  wire logic       clk,
  // levels asked for by the host side
  input  wire logic [5:0] pin_cmd,
  input  wire logic [9:0] good_cmd,
  // levels seen at the block
  output logic      [5:0] pin_out,
  output logic      [9:0] good_out
);
  // board lag of one cycle
  always @(posedge clk)
  begin
    pin_out <= pin_cmd;
    good_out <= good_cmd;
  end
endmodule // rtes_pins_model

`default_nettype wire

//--- testbench/rtes_top_asserts.sv
// assertion checker for the rail two enable sequencing block
`timescale 1ns/1ps
`default_nettype none

module rtes_top_chk #(
  parameter MS_CYCLES = 10
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [7:0] otp_enable_select,
  // rail control
  input wire logic       converter_two_enable_q,
  input wire logic       rail_two_step_size_q,
  input wire logic       delay_pending_q
);
  localparam int PEND_MAX = 64 * MS_CYCLES + 4;
  int pend_cnt_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // length of the current pending stretch
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_cnt_q <= 0;
    else
      pend_cnt_q <= delay_pending_q ? pend_cnt_q + 1 : 0;
  end

  a_read_unmapped: assert property (reg_rd && !(reg_addr inside {8'h0a, 8'h0b, 8'h0c}) |=>
    reg_rdata_q == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  a_write_readback: assert property (reg_wr && reg_addr == 8'h0c ##1 !reg_wr ##1
    reg_rd && !reg_wr && reg_addr == 8'h0c |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("read back differs from write");
  a_step_follow: assert property (reg_wr && reg_addr == 8'h0b |->
    ##2 rail_two_step_size_q == $past(reg_wdata[5], 2)) else $error("step size not taken");
  a_step_quiet: assert property ($changed(rail_two_step_size_q) |->
    ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h0b) || !$past(rst_n, 3))
    else $error("step size moved on its own");
  a_otp_default: assert property ($rose(rst_n) |-> ##2 rail_two_step_size_q == otp_enable_select[5])
    else $error("step size default not loaded");
  a_pending_bound: assert property (pend_cnt_q <= PEND_MAX)
    else $error("edge delay ran too long");
  a_pending_ends: assert property ($past(delay_pending_q) && $changed(converter_two_enable_q) |->
    !delay_pending_q) else $error("pending left high after enable change");

  c_enable_rise: cover property ($rose(converter_two_enable_q));
  c_pending: cover property ($rose(delay_pending_q));
  c_read: cover property (reg_rd ##1 reg_rdata_q != 8'h00);
endmodule // rtes_top_chk

bind rtes_top rtes_top_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .otp_enable_select(otp_enable_select),
  .converter_two_enable_q(converter_two_enable_q), .rail_two_step_size_q(rail_two_step_size_q),
  .delay_pending_q(delay_pending_q));

`default_nettype wire

//--- testbench/test_rtes_top.sv
// testbench for the rail two enable sequencing block
`timescale 1ns/1ps
`default_nettype none

module test_rtes_top;
  localparam int M = 10;
  logic       clk, rst_n, reg_wr, reg_rd, probe, rd_seen, probe_seen, stp;
  logic [7:0] reg_addr, reg_wdata, otp_a, otp_b, otp_c, rdata, v;
  logic [5:0] pin_cmd, pin;
  logic [9:0] good_cmd, good;
  logic       en, step, pend;
  logic [7:0] exp_q[$];
  int         mismatches, n_checks, seed;
  int         ms_tab[8] = '{0, 2, 4, 8, 16, 24, 32, 64};

  rtes_top #(.MS_CYCLES(M)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(rdata), .otp_mask_a(otp_a), .otp_enable_select(otp_b),
    .otp_edge_delay(otp_c), .control_pin(pin), .power_good_converter_one(good[0]),
    .power_good_converter_three(good[1]), .power_good_converter_four(good[2]),
    .power_good_converter_five(good[3]), .power_good_converter_six(good[4]),
    .power_good_load_switch_a_one(good[5]), .power_good_aux_regulator_two(good[6]),
    .power_good_aux_regulator_three(good[7]), .power_good_load_switch_b_one(good[8]),
    .power_good_switch_b_two_aux_reg_one(good[9]), .converter_two_enable_q(en),
    .rail_two_step_size_q(step), .delay_pending_q(pend));
  rtes_pins_model i_far (.clk(clk), .pin_cmd(pin_cmd), .good_cmd(good_cmd), .pin_out(pin), .good_out(good));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // note pending, step and enable, then let the monitor look
  task automatic look(input int n, input logic p, input logic e);
    repeat (n) @(posedge clk);
    exp_q.push_back({5'h00, p, stp, e});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask

  // masks with the constant source selected
  task automatic setmask(input logic [9:0] m);
    wr(8'h0a, m[7:0]);
    wr(8'h0b, {2'b11, stp, 3'h7, m[9:8]});
  endtask

  function automatic logic [5:0] need_of(input logic [2:0] s);
    case (s)
      3'h0: need_of = 6'h01;
      3'h1: need_of = 6'h02;
      3'h2: need_of = 6'h10;
      3'h3: need_of = 6'h08;
      3'h4: need_of = 6'h04;
      3'h5: need_of = 6'h0c;
      3'h6: need_of = 6'h20;
      default: need_of = 6'h00;
    endcase
  endfunction

  always @(posedge clk)
  begin
    if (rd_seen || probe_seen)
      chk(rd_seen ? rdata : {5'h00, pend, step, en}, exp_q.pop_front());
    rd_seen <= reg_rd;
    probe_seen <= probe;
  end

  initial
  begin
    #200000;
    mismatches++;
    close_out;
  end

  initial
  begin
    seed = $urandom(32'h03776cba);
    {rst_n, reg_wr, reg_rd, probe} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pin_cmd = 6'h00;
    good_cmd = 10'h3ff;
    otp_a = $urandom;
    otp_b = $urandom;
    otp_c = $urandom;
    stp = otp_b[5];
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h0a, otp_a);
    rd(8'h0b, otp_b);
    rd(8'h0c, otp_c);
    rd(8'h0d, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      v = $urandom;
      if (i == 1)
        v[5] = stp;
      wr(8'h0a + 8'(i), v);
      rd(8'h0a + 8'(i), v);
    end
    wr(8'h0c, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      stp = ~stp;
      setmask(10'h3ff);
      look(8, 1'b0, 1'b1);
    end
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h0b, {2'b11, stp, 3'(s), 2'b11});
      pin_cmd <= ~need_of(3'(s));
      look(8, 1'b0, s == 7);
      pin_cmd <= (s == 5) ? 6'h04 : need_of(3'(s));
      look(8, 1'b0, s != 5);
      pin_cmd <= need_of(3'(s));
      look(8, 1'b0, 1'b1);
    end
    setmask(10'h000);
    for (int g = 0; g < 10; g++)
    begin
      good_cmd <= ~(10'h001 << g);
      look(8, 1'b0, 1'b0);
      setmask(10'h001 << g);
      look(8, 1'b0, 1'b1);
      // restore goods before the next step so good_cmd changes once per time step
      good_cmd <= 10'h3ff;
      setmask(10'h000);
    end
    wr(8'h0b, {2'b11, stp, 3'h0, 2'b11});
    pin_cmd <= 6'h00;
    look(8, 1'b0, 1'b0);
    for (int d = 1; d < 8; d++)
    begin
      wr(8'h0c, {2'b00, 3'(8 - d), 3'(d)});
      pin_cmd <= 6'h01;
      look(ms_tab[d] * M, 1'b1, 1'b0);
      look(6, 1'b0, 1'b1);
      pin_cmd <= 6'h00;
      look(ms_tab[8 - d] * M, 1'b1, 1'b1);
      look(6, 1'b0, 1'b0);
    end
    wr(8'h0c, 8'h01);
    pin_cmd <= 6'h01;
    look(10, 1'b1, 1'b0);
    pin_cmd <= 6'h00;
    look(30, 1'b0, 1'b0);
    pin_cmd <= 6'h01;
    look(2 * M, 1'b1, 1'b0);
    look(6, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0)
      mismatches++;
    close_out;
  end
endmodule // test_rtes_top

`default_nettype wire
